/* dssc_regs.svh */
// Register indices, field positions and reset values for the debug state sequencer.
// Assumes a 32-bit AHB-Lite slave: byte address is four times the index.
// Notes on behaviour
// (RQ1) State2 uses channel 0 and 1 selects
// (RQ2) State2 channel 3 select, or external event
// (RQ3) State2 codes: hold, State1, State3, Final
// (RQ4) State3 uses channel 0 and 1 selects
// (RQ5) State3 channel 3 select, or external event
// (RQ6) State3 codes: hold, State1, State2, Final
// (RQ7) Highest matching channel wins
// (RQ8) State controls writable only while disarmed
// (RQ9) Only enabled comparators produce matches
// (RQ10) Event flags are read-only, set while armed
// (RQ11) Non-trigger flags set only when already armed
// (RQ12) Trigger flag set armed or while arming
// (RQ13) Flags cleared only by arming
// (RQ14) Set flags never block other flags
// (RQ15) Trigger bit 6, external 4, matches 3-0
// (RQ16) State field follows each transition
// (RQ17) Software disarm keeps last state
// (RQ18) Internal end returns State0, field zero
// (RQ19) Arming enters State1, field 001
// (RQ20) State field encodes State0 to Final
// (RQ21) Arm clears itself at session end
// (RQ22) Trigger request forces Final, reads zero
// (RQ23) External event replaces channel 3
// (RQ24) Reserved state codes never entered
`ifndef DSSC_REGS_SVH
`define DSSC_REGS_SVH
`define DSSC_IDX_W 10
`define DSSC_IDX_CTRL 10'h100
`define DSSC_IDX_SCR2 10'h108
`define DSSC_IDX_SCR3 10'h109
`define DSSC_IDX_FLAGS 10'h10A
`define DSSC_IDX_STAT 10'h10B
`define DSSC_CTRL_ARM 7
`define DSSC_CTRL_TRIGGER 6
`define DSSC_ESEL_LSB 0
`define DSSC_ESEL_EXT 2'h2
`define DSSC_C0_LSB 0
`define DSSC_C1_LSB 2
`define DSSC_C3_LSB 6
`define DSSC_F_TRIGGER 6
`define DSSC_F_EXT 4
`define DSSC_RST_BYTE 8'h00
`define DSSC_RST_ESEL 2'h0
`define DSSC_CODE_HOLD 2'h0
`define DSSC_CODE_A 2'h1
`define DSSC_CODE_B 2'h2
`define DSSC_CODE_FIN 2'h3
`endif

/* dssc_pkg.sv */
// Types shared by the debug state sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dssc_pkg;
    // Sequencer states as reported in the status field
    typedef enum logic [2:0] {
        DSSC_S0 = 3'h0,
        DSSC_S1 = 3'h1,
        DSSC_S2 = 3'h2,
        DSSC_S3 = 3'h3,
        DSSC_FIN = 3'h4
    } dssc_state_t;
    typedef logic [1:0] dssc_code_t;
endpackage : dssc_pkg
`default_nettype wire

/* dssc_top.sv */
// Debug state sequencer: state2/state3 controls, event flags, state status.
// Assumes matches come from the comparators on hclk; the external event is a pin.
// One AHB-Lite slave with zero wait states; only the low byte of each word is used.
// State1 selects and comparator enables arrive as levels from the surrounding debug logic.
`include "dssc_regs.svh"
`default_nettype none
module dssc_top #(
    parameter int ADDR_W = 12,
    parameter int CHANS = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CHANS-1:0] comparator_match,
    input wire logic [CHANS-1:0] comparator_enable,
    input wire logic [7:0] state1_next_state_ctrl,
    input wire logic external_event,
    output logic armed,
    output logic session_end_req
);

    // Target state for a select code; code 00 keeps the present state
    // Codes 01 and 10 name different states in State1, State2 and State3, so the
    // present state picks the meaning; Final and State0 never reach this function
    function automatic dssc_pkg::dssc_state_t dssc_target(
        input dssc_pkg::dssc_state_t cur,
        input dssc_pkg::dssc_code_t code
    );
        dssc_pkg::dssc_state_t t;
        t = cur;
        unique case (code)
            `DSSC_CODE_HOLD: t = cur;
            `DSSC_CODE_A: begin
                if (cur == dssc_pkg::DSSC_S1) begin
                    t = dssc_pkg::DSSC_S2;
                end else begin
                    t = dssc_pkg::DSSC_S1; // RQ3 RQ6
                end
            end
            `DSSC_CODE_B: begin
                if (cur == dssc_pkg::DSSC_S3) begin
                    t = dssc_pkg::DSSC_S2; // RQ6
                end else begin
                    t = dssc_pkg::DSSC_S3; // RQ3
                end
            end
            `DSSC_CODE_FIN: t = dssc_pkg::DSSC_FIN; // RQ3 RQ6
        endcase
        return t;
    endfunction : dssc_target

    // Field extraction used for every control byte
    function automatic dssc_pkg::dssc_code_t dssc_field(
        input logic [7:0] ctl,
        input int lsb
    );
        return ctl[lsb +: 2];
    endfunction : dssc_field

    logic [7:0] scr2;
    logic [7:0] scr3;
    logic [7:0] flags;
    logic [1:0] ext_sel;
    dssc_pkg::dssc_state_t seq_state;
    dssc_pkg::dssc_state_t next_state;
    logic wr_pend;
    logic [`DSSC_IDX_W-1:0] wr_idx;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic rd_ctrl;

    // Address phase decode
    logic addr_ok;
    logic [`DSSC_IDX_W-1:0] a_idx;
    assign addr_ok = hsel && htrans[1] && hready;
    assign a_idx = haddr[`DSSC_IDX_W+1:2];

    // Data phase write strobes
    logic wr_ctrl;
    logic wr_scr2;
    logic wr_scr3;
    assign wr_ctrl = wr_pend && (wr_idx == `DSSC_IDX_CTRL);
    assign wr_scr2 = wr_pend && (wr_idx == `DSSC_IDX_SCR2);
    assign wr_scr3 = wr_pend && (wr_idx == `DSSC_IDX_SCR3);

    // Session events
    logic arm_set;
    logic session_end;
    logic trigger_req;
    logic ext_pulse;
    logic [CHANS-1:0] eff_match;
    logic chan3_in;
    // Final lasts one cycle whatever the arm bit says: a trigger written together with a
    // software disarm must not leave the sequencer parked in Final
    assign session_end = (seq_state == dssc_pkg::DSSC_FIN); // RQ18
    assign arm_set = wr_ctrl && hwdata[`DSSC_CTRL_ARM] && !armed; // RQ19
    assign trigger_req = wr_ctrl && hwdata[`DSSC_CTRL_TRIGGER]
        && (armed || hwdata[`DSSC_CTRL_ARM]); // RQ22
    assign ext_pulse = ext_s2 && !ext_s3;
    // A disabled comparator reaches neither the sequencer nor the flags
    assign eff_match = comparator_match & comparator_enable; // RQ9
    // Select 10 hands channel 3's slot to the pin edge; the comparator still sets its flag
    assign chan3_in = (ext_sel == `DSSC_ESEL_EXT) ? ext_pulse : eff_match[3]; // RQ23 RQ2 RQ5

    // Quiet cycle: no bus action competes with the match logic
    logic seq_free;
    assign seq_free = armed && !wr_ctrl && !session_end;

    // External event pin synchroniser and rising edge detect
    // The third flop only feeds the edge detect, so the pin meets two flops first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_event;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // Bus answers at once; every transfer is OKAY
    // No register needs time to answer, so hreadyout never drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write address capture for the data phase
    // Index is captured every cycle; wr_pend alone says whether it means anything
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_idx <= a_idx;
        end
    end

    // Read mux for the byte at an index; unmapped reads zero
    function automatic logic [7:0] dssc_read(
        input logic [`DSSC_IDX_W-1:0] idx,
        input logic arm_v,
        input logic [1:0] esel_v,
        input logic [7:0] s2,
        input logic [7:0] s3,
        input logic [7:0] fl,
        input logic [2:0] st
    );
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            `DSSC_IDX_CTRL: begin
                r[`DSSC_CTRL_ARM] = arm_v; // trigger bit reads 0 (RQ22)
                r[`DSSC_ESEL_LSB +: 2] = esel_v;
            end
            `DSSC_IDX_SCR2: r = s2;
            `DSSC_IDX_SCR3: r = s3;
            `DSSC_IDX_FLAGS: r = fl;
            `DSSC_IDX_STAT: r = {5'h00, st}; // RQ20
            default: r = 8'h00;
        endcase
        return r;
    endfunction : dssc_read

    // Read data latched at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            rd_ctrl <= 1'b0;
        end else begin
            rd_ctrl <= addr_ok && !hwrite && (a_idx == `DSSC_IDX_CTRL);
            if (addr_ok && !hwrite) begin
                hrdata <= {24'h00_0000, dssc_read(a_idx, armed, ext_sel, scr2, scr3,
                    flags, seq_state)};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // State control bytes are locked while armed (RQ8)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scr2 <= `DSSC_RST_BYTE;
            scr3 <= `DSSC_RST_BYTE;
        end else begin
            if (wr_scr2 && !armed) begin
                scr2 <= hwdata[7:0]; // RQ8
            end
            if (wr_scr3 && !armed) begin
                scr3 <= hwdata[7:0]; // RQ8
            end
        end
    end

    // Arm bit: hardware end of session beats a simultaneous write
    // Event select follows a write only from the disarmed state, like the state controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed <= 1'b0;
            ext_sel <= `DSSC_RST_ESEL;
            session_end_req <= 1'b0;
        end else begin
            session_end_req <= session_end;
            if (session_end) begin
                armed <= 1'b0; // RQ21
            end else if (wr_ctrl) begin
                armed <= hwdata[`DSSC_CTRL_ARM];
            end
            if (wr_ctrl && !armed) begin
                ext_sel <= hwdata[`DSSC_ESEL_LSB +: 2];
            end
        end
    end

    // Next state: end, arming, trigger request, then channel priority
    always_comb begin
        dssc_pkg::dssc_code_t code;
        logic [7:0] ctl;
        code = `DSSC_CODE_HOLD;
        ctl = 8'h00;
        next_state = seq_state;
        unique case (seq_state)
            dssc_pkg::DSSC_S1: ctl = state1_next_state_ctrl;
            dssc_pkg::DSSC_S2: ctl = scr2; // RQ1 RQ2
            dssc_pkg::DSSC_S3: ctl = scr3; // RQ4 RQ5
            dssc_pkg::DSSC_S0, dssc_pkg::DSSC_FIN: ctl = 8'h00;
        endcase
        if (chan3_in) begin
            code = dssc_field(ctl, `DSSC_C3_LSB); // RQ7
        end else if (eff_match[1]) begin
            code = dssc_field(ctl, `DSSC_C1_LSB); // RQ1 RQ4
        end else if (eff_match[0]) begin
            code = dssc_field(ctl, `DSSC_C0_LSB); // RQ1 RQ4
        end
        if (session_end) begin
            next_state = dssc_pkg::DSSC_S0; // RQ18
        end else if (arm_set) begin
            next_state = trigger_req ? dssc_pkg::DSSC_FIN : dssc_pkg::DSSC_S1; // RQ19
        end else if (!armed) begin
            next_state = seq_state; // RQ17
        end else if (trigger_req) begin
            next_state = dssc_pkg::DSSC_FIN; // RQ22
        end else if (wr_ctrl) begin
            next_state = seq_state; // RQ17
        end else if (seq_state != dssc_pkg::DSSC_FIN) begin
            next_state = dssc_target(seq_state, code); // RQ24
        end
    end

    // State register is the status field itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_state <= dssc_pkg::DSSC_S0;
        end else begin
            seq_state <= next_state; // RQ16
        end
    end

    // Event flags: cleared only by arming; each bit set independently
    // Non-trigger events in the arming cycle are lost on purpose: arm is not yet set
    // then. Only the trigger flag may be set by the same write that arms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= `DSSC_RST_BYTE;
        end else if (arm_set) begin
            flags <= `DSSC_RST_BYTE; // RQ13
            flags[`DSSC_F_TRIGGER] <= trigger_req; // RQ12
        end else if (armed) begin
            flags[3:0] <= flags[3:0] | eff_match; // RQ11 RQ14 RQ15
            if (ext_pulse) begin
                flags[`DSSC_F_EXT] <= 1'b1; // RQ10 RQ15
            end
            if (trigger_req) begin
                flags[`DSSC_F_TRIGGER] <= 1'b1; // RQ12
            end
        end
    end

    // Checks on the sequencer and flags
    // The select checks are written per field so that a wrong field or a wrong code
    // table each trips a different label
    default clocking dssc_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s2_idle_seq;
        seq_free && seq_state == dssc_pkg::DSSC_S2;
    endsequence

    sequence end_seq;
        seq_state == dssc_pkg::DSSC_S0 && !armed && session_end_req;
    endsequence

    sequence s3_idle_seq;
        seq_free && seq_state == dssc_pkg::DSSC_S3;
    endsequence

    arm_enter_a: assert property ((arm_set && !trigger_req) |=> seq_state == dssc_pkg::DSSC_S1) // RQ19
        else $error("arming did not enter State1");
    final_exit_a: assert property (session_end |=> end_seq) // RQ18
        else $error("final state did not end the session");
    trigger_jump_a: assert property ((armed && trigger_req && !session_end) |=> // RQ22
        seq_state == dssc_pkg::DSSC_FIN)
        else $error("trigger request did not force final state");
    locked_scr_a: assert property ((wr_scr2 && armed) |=> $stable(scr2)) // RQ8
        else $error("state2 control changed while armed");
    flags_keep_a: assert property ((!armed && !arm_set) |=> $stable(flags)) // RQ13
        else $error("flags changed while disarmed");
    disarm_keep_a: assert property ((!armed && !arm_set && !session_end) ##1 (!armed && !arm_set) |-> // RQ17
        $stable(seq_state))
        else $error("state moved while disarmed");
    no_reserved_a: assert property (seq_state <= dssc_pkg::DSSC_FIN) // RQ24
        else $error("reserved state code reached");
    immediate_trigger_request_read_a: assert property (rd_ctrl |-> !hrdata[`DSSC_CTRL_TRIGGER]) // RQ22
        else $error("trigger request bit read back as one");
    s2_chan0_a: assert property ((s2_idle_seq and (eff_match[1:0] == 2'h1) and !chan3_in // RQ1
        and (dssc_field(scr2, `DSSC_C0_LSB) == `DSSC_CODE_B)) |=> seq_state == dssc_pkg::DSSC_S3)
        else $error("state2 channel 0 select ignored");
    s2_ext_a: assert property ((s2_idle_seq and ext_pulse and ext_sel == `DSSC_ESEL_EXT // RQ2
        and dssc_field(scr2, `DSSC_C3_LSB) == `DSSC_CODE_FIN) |=> seq_state == dssc_pkg::DSSC_FIN)
        else $error("external event did not steer state2");
    s3_prio_a: assert property ((seq_free && seq_state == dssc_pkg::DSSC_S3 && eff_match[3] // RQ7
        && eff_match[0] && ext_sel != `DSSC_ESEL_EXT && dssc_field(scr3, `DSSC_C3_LSB) == `DSSC_CODE_A
        && dssc_field(scr3, `DSSC_C0_LSB) == `DSSC_CODE_B) |=> seq_state == dssc_pkg::DSSC_S1)
        else $error("channel priority wrong in state3");
    match_flag_a: assert property ((armed && !arm_set && eff_match[0]) |=> flags[0]) // RQ11
        else $error("match flag not set");

    // Further select, flag, disarm and lock checks
    s2_chan1_a: assert property ((s2_idle_seq and eff_match[1] and !chan3_in // RQ1 RQ3
        and dssc_field(scr2, `DSSC_C1_LSB) == `DSSC_CODE_A) |=> seq_state == dssc_pkg::DSSC_S1)
        else $error("state2 channel 1 select ignored");
    s3_chan0_a: assert property ((s3_idle_seq and eff_match[1:0] == 2'h1 and !chan3_in // RQ4 RQ6
        and dssc_field(scr3, `DSSC_C0_LSB) == `DSSC_CODE_B) |=> seq_state == dssc_pkg::DSSC_S2)
        else $error("state3 channel 0 select ignored");
    ext_masks_a: assert property ((s2_idle_seq and ext_sel == `DSSC_ESEL_EXT and !ext_pulse // RQ23
        and eff_match[3] and eff_match[1:0] == 2'h0) |=> seq_state == dssc_pkg::DSSC_S2)
        else $error("comparator 3 moved the sequencer in place of the pin");
    immediate_trigger_request_flag_a: assert property ((arm_set && trigger_req) |=> flags[`DSSC_F_TRIGGER]) // RQ12
        else $error("trigger flag not set while arming");
    ext_flag_a: assert property ((armed && !arm_set && ext_pulse) |=> flags[`DSSC_F_EXT]) // RQ10 RQ15
        else $error("external event flag not set");
    flags_sticky_a: assert property ((armed && !arm_set) |=> ((flags & $past(flags)) == $past(flags))) // RQ14
        else $error("a set flag was lost during the session");
    soft_keep_a: assert property ((armed && wr_ctrl && !hwdata[`DSSC_CTRL_ARM] // RQ17
        && !hwdata[`DSSC_CTRL_TRIGGER] && !session_end) |=> (!armed && $stable(seq_state)))
        else $error("software disarm moved the state field");
    locked_scr3_a: assert property ((wr_scr3 && armed) |=> $stable(scr3)) // RQ8
        else $error("state3 control changed while armed");

endmodule : dssc_top
`default_nettype wire

/* dssc_cpu_model.sv */
// CPU-side model: comparator matches and enables, State1 selects, external event pin.
// Assumes the bench calls its tasks; every change lands just after a rising hclk edge.
`default_nettype none
module dssc_cpu_model (
    input wire logic hclk,
    output logic [3:0] comparator_match,
    output logic [3:0] comparator_enable,
    output logic [7:0] state1_next_state_ctrl,
    output logic external_event
);
    // Quiet at time zero: no matches, comparators off, pin low
    initial begin
        comparator_match = 4'h0;
        comparator_enable = 4'h0;
        state1_next_state_ctrl = 8'h00;
        external_event = 1'b0;
    end

    // Enables come from each comparator's own control bit
    task automatic setup(input logic [3:0] en, input logic [7:0] s1);
        @(posedge hclk);
        comparator_enable <= en;
        state1_next_state_ctrl <= s1;
    endtask : setup

    // Match pulses last one cycle, as the comparators give them
    task automatic fire(input logic [3:0] mask);
        @(posedge hclk);
        comparator_match <= mask;
        @(posedge hclk);
        comparator_match <= 4'h0;
    endtask : fire

    // Held several cycles so the pin survives the synchroniser
    task automatic pulse_ext();
        @(posedge hclk);
        external_event <= 1'b1;
        repeat (4) @(posedge hclk);
        external_event <= 1'b0;
    endtask : pulse_ext
endmodule : dssc_cpu_model
`default_nettype wire

/* debug_state_sequencer_ctrl_test.sv */
// Bench for the debug state sequencer: AHB-Lite master tasks and one task per scenario.
// Assumes dssc_top answers with zero or more wait states and the CPU-side model beside it.
`include "dssc_regs.svh"
`default_nettype none
module debug_state_sequencer_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] comparator_match;
    logic [3:0] comparator_enable;
    logic [7:0] state1_next_state_ctrl;
    logic external_event;
    logic armed;
    logic session_end_req;
    int n_errors = 0;
    int checks = 0;
    int n_ends = 0;

    // 100 ns period
    always #50 hclk = ~hclk;

    dssc_top #(.ADDR_W(12), .CHANS(4)) dssc_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comparator_match(comparator_match),
        .comparator_enable(comparator_enable), .state1_next_state_ctrl(state1_next_state_ctrl),
        .external_event(external_event), .armed(armed), .session_end_req(session_end_req)
    );

    dssc_cpu_model dssc_cpu_model_i (
        .hclk(hclk), .comparator_match(comparator_match), .comparator_enable(comparator_enable),
        .state1_next_state_ctrl(state1_next_state_ctrl), .external_event(external_event)
    );

    // Count end-of-session pulses; a pulse stands one cycle so it is counted at one edge only
    always @(posedge hclk) begin
        if (session_end_req === 1'b1) n_ends++;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask : check

    // One single word transfer; each phase held until hready is sampled high
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rb);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {idx, 2'b00};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 16);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 32);
        rb = hrdata[7:0];
        check({7'h00, hresp}, 8'h00);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
    endtask : bus

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        logic [7:0] rb;
        bus(1'b1, idx, wd, rb);
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        logic [7:0] rb;
        bus(1'b0, idx, 8'h00, rb);
        check(rb, exp);
    endtask : rd_chk

    // Pulse matches, then read the state field back
    task automatic step(input logic [3:0] mask, input logic [7:0] exp);
        dssc_cpu_model_i.fire(mask);
        rd_chk(`DSSC_IDX_STAT, exp);
    endtask : step

    task automatic check_reset();
        rd_chk(`DSSC_IDX_STAT, 8'h00);
        rd_chk(`DSSC_IDX_FLAGS, 8'h00);
        rd_chk(10'h3FF, 8'h00);
    endtask : check_reset

    // Controls take writes only while disarmed; flags ignore writes
    task automatic check_access();
        wr(`DSSC_IDX_SCR2, 8'hC6);
        rd_chk(`DSSC_IDX_SCR2, 8'hC6);
        wr(`DSSC_IDX_SCR3, 8'h4E);
        wr(`DSSC_IDX_FLAGS, 8'hFF);
        rd_chk(`DSSC_IDX_FLAGS, 8'h00);
        wr(`DSSC_IDX_CTRL, 8'h80);
        rd_chk(`DSSC_IDX_STAT, 8'h01);
        wr(`DSSC_IDX_SCR3, 8'h00);
        rd_chk(`DSSC_IDX_SCR3, 8'h4E);
        wr(`DSSC_IDX_SCR2, 8'h00);
        rd_chk(`DSSC_IDX_SCR2, 8'hC6);
        check({7'h00, armed}, 8'h01);
    endtask : check_access

    // State2 controls 0xC6 and State3 controls 0x4E drive a full tour
    task automatic walk_states();
        dssc_cpu_model_i.setup(4'hF, 8'h01);
        step(4'h1, 8'h02);
        step(4'h3, 8'h01);
        step(4'h1, 8'h02);
        step(4'h1, 8'h03);
        step(4'h1, 8'h02);
        step(4'h1, 8'h03);
        step(4'h9, 8'h01);
        dssc_cpu_model_i.setup(4'h0, 8'h01);
        step(4'h1, 8'h01);
        dssc_cpu_model_i.fire(4'h4);
        rd_chk(`DSSC_IDX_FLAGS, 8'h0B);
        dssc_cpu_model_i.setup(4'hF, 8'h01);
        step(4'h3, 8'h01);
        step(4'h1, 8'h02);
        step(4'h8, 8'h00);
        check({7'h00, armed}, 8'h00);
        rd_chk(`DSSC_IDX_FLAGS, 8'h0B);
    endtask : walk_states

    // Software disarm keeps the field; disarmed matches leave flags alone
    task automatic soft_disarm();
        wr(`DSSC_IDX_CTRL, 8'h80);
        rd_chk(`DSSC_IDX_FLAGS, 8'h00);
        step(4'h1, 8'h02);
        wr(`DSSC_IDX_CTRL, 8'h00);
        rd_chk(`DSSC_IDX_STAT, 8'h02);
        dssc_cpu_model_i.fire(4'h2);
        rd_chk(`DSSC_IDX_FLAGS, 8'h01);
    endtask : soft_disarm

    // Trigger written with the arm bit ends the session at once
    task automatic trigger_arm();
        wr(`DSSC_IDX_CTRL, 8'hC0);
        rd_chk(`DSSC_IDX_STAT, 8'h00);
        rd_chk(`DSSC_IDX_FLAGS, 8'h40);
        rd_chk(`DSSC_IDX_CTRL, 8'h00);
        wr(`DSSC_IDX_CTRL, 8'h80);
        wr(`DSSC_IDX_CTRL, 8'hC0);
        rd_chk(`DSSC_IDX_STAT, 8'h00);
        rd_chk(`DSSC_IDX_FLAGS, 8'h40);
    endtask : trigger_arm

    // With select 10 the pin replaces channel 3; the synchroniser adds two cycles
    task automatic external_route();
        wr(`DSSC_IDX_CTRL, 8'h02);
        wr(`DSSC_IDX_CTRL, 8'h82);
        step(4'h1, 8'h02);
        step(4'h8, 8'h02);
        dssc_cpu_model_i.pulse_ext();
        repeat (6) @(posedge hclk);
        rd_chk(`DSSC_IDX_STAT, 8'h00);
        rd_chk(`DSSC_IDX_FLAGS, 8'h19);
        check(n_ends[7:0], 8'h04);
    endtask : external_route

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        check_reset();
        check_access();
        walk_states();
        soft_disarm();
        trigger_arm();
        external_route();
        give_verdict();
    end
endmodule : debug_state_sequencer_ctrl_test
`default_nettype wire
